// File: shared/csn_regs.vh
// Object indexes, identifiers, command codes and timing of the sensor node
`ifndef CSN_REGS_VH
`define CSN_REGS_VH
`define CSN_IDX_ERR_REG 16'h1001
`define CSN_IDX_MSTAT 16'h1002
`define CSN_IDX_TS_ID 16'h1012
`define CSN_IDX_HB 16'h1017
`define CSN_IDX_LIM4 16'h3000
`define CSN_IDX_LIM6 16'h3001
`define CSN_IDX_LIM14 16'h3002
`define CSN_IDX_SENDN 16'h3003
`define CSN_IDX_LOG_IVL 16'h4000
`define CSN_IDX_LOG_CNT 16'h4001
`define CSN_IDX_REC_FIRST 16'h4002
`define CSN_IDX_REC_LAST 16'h43e9
`define CSN_IDX_PV_INT 16'h5000
`define CSN_IDX_PV_REAL 16'h5100
`define CSN_TS_ID_RST 32'h00000100
`define CSN_TS_ID_EN_BIT 31
`define CSN_SENDN_RST 16'h0001
`define CSN_LOG_IVL_MAX 32'h000003e8
`define CSN_LOG_DEPTH 1000
`define CSN_REC_ENTRIES 8'h09
`define CSN_PV_ENTRIES 8'h04
`define CSN_COB_NMT 11'h000
`define CSN_COB_EMCY 11'h080
`define CSN_COB_PDO 11'h180
`define CSN_COB_SDO_TX 11'h580
`define CSN_COB_SDO_RX 11'h600
`define CSN_COB_ERRCTL 11'h700
`define CSN_CS_WR1 8'h2f
`define CSN_CS_WR2 8'h2b
`define CSN_CS_WR3 8'h27
`define CSN_CS_WR4 8'h23
`define CSN_CS_WR_OK 8'h60
`define CSN_CS_ABORT 8'h80
`define CSN_CS_RD 8'h40
`define CSN_CS_RD1 8'h4f
`define CSN_CS_RD2 8'h4b
`define CSN_CS_RD3 8'h47
`define CSN_CS_RD4 8'h43
`define CSN_AB_ACCESS 32'h06010000
`define CSN_AB_RO 32'h06010002
`define CSN_AB_NOOBJ 32'h06020000
`define CSN_AB_SUB 32'h06090011
`define CSN_AB_RANGE 32'h06090030
`define CSN_AB_CMD 32'h05040001
`define CSN_NMT_START 8'h01
`define CSN_NMT_STOP 8'h02
`define CSN_NMT_PREOP 8'h80
`define CSN_NMT_RST_NODE 8'h81
`define CSN_NMT_RST_COMM 8'h82
`define CSN_ST_BOOT 8'h00
`define CSN_ST_STOP 8'h04
`define CSN_ST_OPER 8'h05
`define CSN_ST_PREOP 8'h7f
`define CSN_MS_FLOW 0
`define CSN_MS_LIM14 1
`define CSN_MS_LIM6 2
`define CSN_MS_LIM4 3
`define CSN_ER_GENERIC 0
`define CSN_EMCY_CODE 16'hff00
`define CSN_CLK_HZ 100000000
`define CSN_MEAS_S 20
`define CSN_HOUR_S 3600
`define CSN_MEAS_CYC (`CSN_MEAS_S * `CSN_CLK_HZ)
`define CSN_MS_CYC (`CSN_CLK_HZ / 1000)
`define CSN_MEAS_PER_HOUR (`CSN_HOUR_S / `CSN_MEAS_S)
`endif

// File: rtl/csn_node.v
// Frame-level communication layer of a particle counting sensor node
// Notes on behaviour
// - Log interval in hours, 0 to 1000, zero stops
// - Record count object; at most 1000 records
// - Writing zero to count erases log
// - Records at consecutive indexes; empty slot aborts
// - Record: nine entries, time bytes, four reals
// - Process values as 16-bit and 32-bit objects
// - SDO request taken while idle in preop or operational gets one reply unless an NMT reset drops it
// - SDO frame: command, index, subindex, data
// - Write commands by size; success answer 60
// - Read command 40; answer gives data length
// - Failure answers 80 with four-byte code
// - Only expedited transfers up to four bytes
// - One transmit PDO, fixed identifier and type
// - PDO carries four 16-bit values; remote request
// - Emergency on limit exceeded or flow fault
// - Emergency: code, error register, status, unused
// - Guarding when heartbeat zero, else heartbeat
// - Guard reply: state with alternating toggle bit
// - Heartbeat sent cyclically without remote frames
// - Time stamp: six bytes, ms and days
// - Time stamp taken only in pre-operational, enabled
// - NMT start, stop, preop, reset node, comm
// - 20 s measurement; PDO every N, zero suppresses
// - Status bit 0 flow, bits 1-3 limits
// - Error register bit 0 on any error
`include "csn_regs.vh"
`timescale 1ns/10ps
`default_nettype none

module csn_fifo #(
    parameter W = 79,
    parameter D = 16,
    parameter AW = 4
) (
    input wire clk,
    input wire rst_n,
    input wire in_valid,
    output wire in_ready,
    input wire [W-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [W-1:0] out_data
);
    reg [W-1:0] mem [0:D-1];
    reg [AW:0] wp_r;
    reg [AW:0] rp_r;
    wire empty = wp_r == rp_r;
    wire full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[rp_r[AW-1:0]];
    always @(posedge clk) begin
        if (in_valid && !full)
            mem[wp_r[AW-1:0]] <= in_data;
    end
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_r <= {(AW+1){1'b0}};
            rp_r <= {(AW+1){1'b0}};
        end else begin
            if (in_valid && !full)
                wp_r <= wp_r + 1'b1;
            if (out_ready && !empty)
                rp_r <= rp_r + 1'b1;
        end
    end
endmodule // csn_fifo

module csn_node #(
    parameter [31:0] MEAS_CYCLES = `CSN_MEAS_CYC,
    parameter [31:0] MS_CYCLES = `CSN_MS_CYC,
    parameter LOG_DEPTH = `CSN_LOG_DEPTH,
    parameter FIFO_DEPTH = 16
) (
    input wire SYS_CLK,
    input wire RST_N,
    input wire [6:0] NODE_NUMBER,
    input wire RX_VALID,
    input wire [10:0] RX_ID,
    input wire RX_RTR,
    input wire [3:0] RX_DLC,
    input wire [63:0] RX_DATA,
    output reg TX_VALID,
    input wire TX_READY,
    output reg [10:0] TX_ID,
    output reg [3:0] TX_DLC,
    output reg [63:0] TX_DATA,
    input wire [63:0] PV_INT,
    input wire [127:0] PV_REAL,
    input wire FLOW_FAULT,
    input wire [39:0] CLOCK_NOW,
    output reg TS_VALID,
    output reg [27:0] TS_MS,
    output reg [15:0] TS_DAYS,
    output reg [7:0] NMT_STATE
);
    localparam S_IDLE = 2'd0, S_READ = 2'd1, S_EXEC = 2'd2, S_SEND = 2'd3;
    localparam F_NONE = 3'd0, F_BOOT = 3'd1, F_EMCY = 3'd2, F_SDO = 3'd3;
    localparam F_GUARD = 3'd4, F_HB = 3'd5, F_PDO = 3'd6;

    wire [10:0] node_number = {4'h0, NODE_NUMBER};
    reg [31:0] ts_id_r;
    reg [15:0] hb_r, sendn_r, ivl_r;
    reg [7:0] lim4_r, lim6_r, lim14_r;
    reg [9:0] cnt_r;
    reg [3:0] status_r, stat_sent_r;
    reg [1:0] sdo_st_r;
    reg [7:0] rq_cmd_r, rq_sub_r;
    reg [15:0] rq_idx_r;
    reg [31:0] rq_val_r;
    reg [63:0] sdo_rsp_r;
    reg [167:0] log_mem [0:LOG_DEPTH-1];
    reg [167:0] mem_q_r;
    reg boot_pend_r, emcy_pend_r, guard_pend_r, hb_pend_r, pdo_pend_r, toggle_r;
    reg [31:0] meas_cnt_r, ms_cnt_r, ivl_cnt_r;
    reg [15:0] hb_cnt_r, pdo_cnt_r;

    wire [7:0] err_reg = {7'h00, |status_r};
    wire preop = NMT_STATE == `CSN_ST_PREOP;
    wire oper = NMT_STATE == `CSN_ST_OPER;
    wire live = preop || oper;
    wire rx_data = RX_VALID && !RX_RTR;
    wire rx_nmt = rx_data && RX_ID == `CSN_COB_NMT && RX_DLC >= 4'h2 &&
        (RX_DATA[15:8] == 8'h00 || RX_DATA[15:8] == {1'b0, NODE_NUMBER});
    wire rx_sdo = rx_data && RX_ID == `CSN_COB_SDO_RX + node_number && RX_DLC == 4'h8;
    wire rx_ts = rx_data && preop && ts_id_r[`CSN_TS_ID_EN_BIT] &&
        RX_ID == ts_id_r[10:0] && RX_DLC >= 4'h6;
    wire rx_guard = RX_VALID && RX_RTR && RX_ID == `CSN_COB_ERRCTL + node_number;
    wire rx_pdo_rtr = RX_VALID && RX_RTR && RX_ID == `CSN_COB_PDO + node_number;

    wire meas_tick = meas_cnt_r == MEAS_CYCLES - 32'h1;
    wire ms_tick = ms_cnt_r == MS_CYCLES - 32'h1;
    wire [31:0] ivl_ticks = ivl_r * `CSN_MEAS_PER_HOUR;
    wire log_due = meas_tick && ivl_r != 16'h0 && ivl_cnt_r + 32'h1 >= ivl_ticks;

    // Object lookup for the latched request
    wire in_rec = rq_idx_r >= `CSN_IDX_REC_FIRST && rq_idx_r <= `CSN_IDX_REC_LAST;
    wire [9:0] slot = rq_idx_r[9:0] - 10'h002;
    reg [31:0] d_val, d_abort;
    reg [2:0] d_len;
    reg d_wr, d_multi;
    always @* begin
        d_val = 32'h0;
        d_abort = 32'h0;
        d_len = 3'd1;
        d_wr = 1'b0;
        d_multi = 1'b0;
        case (rq_idx_r)
            `CSN_IDX_ERR_REG: d_val = {24'h0, err_reg};
            `CSN_IDX_MSTAT: begin
                d_val = {28'h0, status_r};
                d_len = 3'd4;
            end
            `CSN_IDX_TS_ID: begin
                d_val = ts_id_r;
                d_len = 3'd4;
                d_wr = 1'b1;
            end
            `CSN_IDX_HB: begin
                d_val = {16'h0, hb_r};
                d_len = 3'd2;
                d_wr = 1'b1;
            end
            `CSN_IDX_LIM4, `CSN_IDX_LIM6, `CSN_IDX_LIM14: begin
                d_val = {24'h0, rq_idx_r[1] ? lim14_r : rq_idx_r[0] ? lim6_r : lim4_r};
                d_wr = 1'b1;
            end
            `CSN_IDX_SENDN, `CSN_IDX_LOG_IVL: begin
                d_val = {16'h0, rq_idx_r[14] ? ivl_r : sendn_r};
                d_len = 3'd2;
                d_wr = 1'b1;
            end
            `CSN_IDX_LOG_CNT: begin
                d_val = {22'h0, cnt_r};
                d_len = 3'd2;
                d_wr = 1'b1;
            end
            `CSN_IDX_PV_INT, `CSN_IDX_PV_REAL: begin
                d_multi = 1'b1;
                d_len = rq_idx_r == `CSN_IDX_PV_INT ? 3'd2 : 3'd4;
                case (rq_sub_r)
                    8'h00: begin
                        d_val = {24'h0, `CSN_PV_ENTRIES};
                        d_len = 3'd1;
                    end
                    8'h01, 8'h02, 8'h03, 8'h04:
                        d_val = rq_idx_r == `CSN_IDX_PV_INT ?
                            {16'h0, PV_INT[{rq_sub_r[1:0] - 2'd1} * 16 +: 16]} :
                            PV_REAL[{rq_sub_r[1:0] - 2'd1} * 32 +: 32];
                    default: d_abort = `CSN_AB_SUB;
                endcase
            end
            default: begin
                d_multi = 1'b1;
                if (!in_rec)
                    d_abort = `CSN_AB_NOOBJ;
                else if ({22'h0, slot} >= {22'h0, cnt_r})
                    d_abort = `CSN_AB_ACCESS;
                else if (rq_sub_r == 8'h00)
                    d_val = {24'h0, `CSN_REC_ENTRIES};
                else if (rq_sub_r <= 8'h05)
                    d_val = {24'h0, mem_q_r[(rq_sub_r[2:0] - 3'd1) * 8 +: 8]};
                else if (rq_sub_r <= 8'h09) begin
                    d_val = mem_q_r[40 + (rq_sub_r[3:0] - 4'd6) * 32 +: 32];
                    d_len = 3'd4;
                end else
                    d_abort = `CSN_AB_SUB;
            end
        endcase
        if (!d_multi && rq_sub_r != 8'h00)
            d_abort = `CSN_AB_SUB;
    end

    // Command handling and answer
    reg [7:0] rs_cmd;
    reg [31:0] rs_val, wv;
    reg wr_ok;
    always @* begin
        wr_ok = 1'b0;
        rs_val = d_abort;
        rs_cmd = `CSN_CS_ABORT;
        case (rq_cmd_r)
            `CSN_CS_WR1: wv = {24'h0, rq_val_r[7:0]};
            `CSN_CS_WR2: wv = {16'h0, rq_val_r[15:0]};
            `CSN_CS_WR3: wv = {8'h0, rq_val_r[23:0]};
            default: wv = rq_val_r;
        endcase
        if (rq_cmd_r == `CSN_CS_RD) begin
            if (d_abort == 32'h0) begin
                rs_val = d_val;
                case (d_len)
                    3'd1: rs_cmd = `CSN_CS_RD1;
                    3'd2: rs_cmd = `CSN_CS_RD2;
                    3'd3: rs_cmd = `CSN_CS_RD3;
                    default: rs_cmd = `CSN_CS_RD4;
                endcase
            end
        end else if (rq_cmd_r == `CSN_CS_WR1 || rq_cmd_r == `CSN_CS_WR2 ||
                     rq_cmd_r == `CSN_CS_WR3 || rq_cmd_r == `CSN_CS_WR4) begin
            if (d_abort != 32'h0)
                rs_val = d_abort;
            else if (!d_wr)
                rs_val = `CSN_AB_RO;
            else if ((rq_idx_r == `CSN_IDX_LOG_IVL && wv > `CSN_LOG_IVL_MAX) ||
                     (rq_idx_r == `CSN_IDX_LOG_CNT && wv != 32'h0))
                rs_val = `CSN_AB_RANGE;
            else begin
                wr_ok = 1'b1;
                rs_cmd = `CSN_CS_WR_OK;
                rs_val = 32'h0;
            end
        end else
            rs_val = `CSN_AB_CMD;
    end
    wire do_wr = sdo_st_r == S_EXEC && wr_ok;
    wire log_clr = do_wr && rq_idx_r == `CSN_IDX_LOG_CNT;
    wire log_store = log_due && ({22'h0, cnt_r} < LOG_DEPTH || log_clr);
    wire [9:0] store_slot = log_clr ? 10'h000 : cnt_r;

    // Frame selection; order decides which source reaches the FIFO first
    reg [2:0] sel;
    reg [10:0] f_id;
    reg [3:0] f_dlc;
    reg [63:0] f_data;
    always @* begin
        sel = F_NONE;
        f_id = 11'h000;
        f_dlc = 4'h0;
        f_data = 64'h0;
        if (boot_pend_r) begin
            sel = F_BOOT;
            f_id = `CSN_COB_ERRCTL + node_number;
            f_dlc = 4'h1;
        end else if (emcy_pend_r) begin
            sel = F_EMCY;
            f_id = `CSN_COB_EMCY + node_number;
            f_dlc = 4'h8;
            f_data = {8'h00, 28'h0, status_r, err_reg,
                      status_r != 4'h0 ? `CSN_EMCY_CODE : 16'h0000};
        end else if (sdo_st_r == S_SEND) begin
            sel = F_SDO;
            f_id = `CSN_COB_SDO_TX + node_number;
            f_dlc = 4'h8;
            f_data = sdo_rsp_r;
        end else if (guard_pend_r) begin
            sel = F_GUARD;
            f_id = `CSN_COB_ERRCTL + node_number;
            f_dlc = 4'h1;
            f_data = {56'h0, toggle_r, NMT_STATE[6:0]};
        end else if (hb_pend_r) begin
            sel = F_HB;
            f_id = `CSN_COB_ERRCTL + node_number;
            f_dlc = 4'h1;
            f_data = {56'h0, NMT_STATE};
        end else if (pdo_pend_r) begin
            sel = F_PDO;
            f_id = `CSN_COB_PDO + node_number;
            f_dlc = 4'h8;
            f_data = PV_INT;
        end
    end
    wire fifo_in_ready, fifo_out_valid;
    wire [78:0] fifo_out;
    wire push = sel != F_NONE && fifo_in_ready;
    wire tx_take = !TX_VALID || TX_READY;
    csn_fifo #(.W(79), .D(FIFO_DEPTH), .AW($clog2(FIFO_DEPTH))) u_txq (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .in_valid(sel != F_NONE),
        .in_ready(fifo_in_ready),
        .in_data({f_id, f_dlc, f_data}),
        .out_valid(fifo_out_valid),
        .out_ready(tx_take),
        .out_data(fifo_out)
    );

    always @(posedge SYS_CLK) begin
        mem_q_r <= log_mem[slot];
        if (log_store)
            log_mem[store_slot] <= {PV_REAL, CLOCK_NOW};
    end

    wire nmt_reset = rx_nmt && (RX_DATA[7:0] == `CSN_NMT_RST_NODE ||
        RX_DATA[7:0] == `CSN_NMT_RST_COMM);
    always @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            TX_VALID <= 1'b0;
            TX_ID <= 11'h000;
            TX_DLC <= 4'h0;
            TX_DATA <= 64'h0;
            TS_VALID <= 1'b0;
            TS_MS <= 28'h0;
            TS_DAYS <= 16'h0;
            NMT_STATE <= `CSN_ST_BOOT;
            ts_id_r <= `CSN_TS_ID_RST;
            hb_r <= 16'h0;
            sendn_r <= `CSN_SENDN_RST;
            ivl_r <= 16'h0;
            lim4_r <= 8'h00;
            lim6_r <= 8'h00;
            lim14_r <= 8'h00;
            cnt_r <= 10'h000;
            status_r <= 4'h0;
            stat_sent_r <= 4'h0;
            sdo_st_r <= S_IDLE;
            rq_cmd_r <= 8'h00;
            rq_sub_r <= 8'h00;
            rq_idx_r <= 16'h0;
            rq_val_r <= 32'h0;
            sdo_rsp_r <= 64'h0;
            boot_pend_r <= 1'b1;
            emcy_pend_r <= 1'b0;
            guard_pend_r <= 1'b0;
            hb_pend_r <= 1'b0;
            pdo_pend_r <= 1'b0;
            toggle_r <= 1'b0;
            meas_cnt_r <= 32'h0;
            ms_cnt_r <= 32'h0;
            ivl_cnt_r <= 32'h0;
            hb_cnt_r <= 16'h0;
            pdo_cnt_r <= 16'h0;
        end else begin
            if (tx_take) begin
                TX_VALID <= fifo_out_valid;
                {TX_ID, TX_DLC, TX_DATA} <= fifo_out;
            end
            TS_VALID <= rx_ts;
            if (rx_ts) begin
                TS_MS <= RX_DATA[27:0];
                TS_DAYS <= RX_DATA[47:32];
            end
            status_r[`CSN_MS_FLOW] <= FLOW_FAULT;
            status_r[`CSN_MS_LIM14] <= lim14_r != 8'h0 && PV_INT[47:32] > {8'h0, lim14_r};
            status_r[`CSN_MS_LIM6] <= lim6_r != 8'h0 && PV_INT[31:16] > {8'h0, lim6_r};
            status_r[`CSN_MS_LIM4] <= lim4_r != 8'h0 && PV_INT[15:0] > {8'h0, lim4_r};
            meas_cnt_r <= meas_tick ? 32'h0 : meas_cnt_r + 32'h1;
            ms_cnt_r <= ms_tick ? 32'h0 : ms_cnt_r + 32'h1;
            if (meas_tick)
                ivl_cnt_r <= log_due || ivl_r == 16'h0 ? 32'h0 : ivl_cnt_r + 32'h1;
            if (log_store)
                cnt_r <= store_slot + 10'h001;
            else if (log_clr)
                cnt_r <= 10'h000;
            // SDO server: one request in flight, others ignored until answered or NMT reset
            case (sdo_st_r)
                S_IDLE:
                    if (rx_sdo && live) begin
                        rq_cmd_r <= RX_DATA[7:0];
                        rq_idx_r <= RX_DATA[23:8];
                        rq_sub_r <= RX_DATA[31:24];
                        rq_val_r <= RX_DATA[63:32];
                        sdo_st_r <= S_READ;
                    end
                S_READ: sdo_st_r <= S_EXEC;
                S_EXEC: begin
                    sdo_rsp_r <= {rs_val, rq_sub_r, rq_idx_r, rs_cmd};
                    sdo_st_r <= S_SEND;
                    if (do_wr) begin
                        case (rq_idx_r)
                            `CSN_IDX_TS_ID: ts_id_r <= wv;
                            `CSN_IDX_HB: hb_r <= wv[15:0];
                            `CSN_IDX_LIM4: lim4_r <= wv[7:0];
                            `CSN_IDX_LIM6: lim6_r <= wv[7:0];
                            `CSN_IDX_LIM14: lim14_r <= wv[7:0];
                            `CSN_IDX_SENDN: sendn_r <= wv[15:0];
                            `CSN_IDX_LOG_IVL: ivl_r <= wv[15:0];
                            default: ;
                        endcase
                    end
                end
                S_SEND:
                    if (push && sel == F_SDO)
                        sdo_st_r <= S_IDLE;
                default: sdo_st_r <= S_IDLE;
            endcase
            // Pending flags: a clear by a push loses to a new event
            if (push && sel == F_BOOT) begin
                boot_pend_r <= 1'b0;
                NMT_STATE <= `CSN_ST_PREOP;
            end
            if (push && sel == F_EMCY)
                emcy_pend_r <= 1'b0;
            if (push && sel == F_GUARD) begin
                guard_pend_r <= 1'b0;
                toggle_r <= ~toggle_r;
            end
            if (push && sel == F_HB)
                hb_pend_r <= 1'b0;
            if (push && sel == F_PDO)
                pdo_pend_r <= 1'b0;
            if (live && status_r != stat_sent_r) begin
                emcy_pend_r <= 1'b1;
                stat_sent_r <= status_r;
            end
            if (rx_guard && hb_r == 16'h0 && NMT_STATE != `CSN_ST_BOOT)
                guard_pend_r <= 1'b1;
            if (ms_tick) begin
                hb_cnt_r <= hb_r == 16'h0 || hb_cnt_r + 16'h1 >= hb_r ? 16'h0 : hb_cnt_r + 16'h1;
                if (hb_r != 16'h0 && hb_cnt_r + 16'h1 >= hb_r && NMT_STATE != `CSN_ST_BOOT)
                    hb_pend_r <= 1'b1;
            end
            if (meas_tick) begin
                pdo_cnt_r <= sendn_r == 16'h0 || pdo_cnt_r + 16'h1 >= sendn_r ?
                    16'h0 : pdo_cnt_r + 16'h1;
                if (sendn_r != 16'h0 && pdo_cnt_r + 16'h1 >= sendn_r && oper)
                    pdo_pend_r <= 1'b1;
            end
            if (rx_pdo_rtr && oper)
                pdo_pend_r <= 1'b1;
            if (rx_nmt && NMT_STATE != `CSN_ST_BOOT) begin
                case (RX_DATA[7:0])
                    `CSN_NMT_START: NMT_STATE <= `CSN_ST_OPER;
                    `CSN_NMT_STOP: NMT_STATE <= `CSN_ST_STOP;
                    `CSN_NMT_PREOP: NMT_STATE <= `CSN_ST_PREOP;
                    default: ;
                endcase
            end
            // Reset node also restores application objects; the log survives
            if (nmt_reset) begin
                NMT_STATE <= `CSN_ST_BOOT;
                boot_pend_r <= 1'b1;
                emcy_pend_r <= 1'b0;
                guard_pend_r <= 1'b0;
                hb_pend_r <= 1'b0;
                pdo_pend_r <= 1'b0;
                toggle_r <= 1'b0;
                stat_sent_r <= 4'h0;
                hb_cnt_r <= 16'h0;
                ts_id_r <= `CSN_TS_ID_RST;
                hb_r <= 16'h0;
                sdo_st_r <= S_IDLE;
                if (RX_DATA[7:0] == `CSN_NMT_RST_NODE) begin
                    sendn_r <= `CSN_SENDN_RST;
                    ivl_r <= 16'h0;
                    lim4_r <= 8'h00;
                    lim6_r <= 8'h00;
                    lim14_r <= 8'h00;
                end
            end
        end
    end
endmodule // csn_node

`default_nettype wire

// File: testbench/csn_node_properties.sv
// Port checks of the sensor node
`timescale 1ns/10ps
`default_nettype none
module csn_node_properties (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic [6:0] NODE_NUMBER,
    input wire logic TX_VALID,
    input wire logic TX_READY,
    input wire logic [10:0] TX_ID,
    input wire logic [3:0] TX_DLC,
    input wire logic [63:0] TX_DATA,
    input wire logic TS_VALID,
    input wire logic [7:0] NMT_STATE
);
    default clocking @(posedge SYS_CLK);
    endclocking
    default disable iff (!RST_N);
    // Frame kind from the top identifier bits, only for this node
    wire [3:0] kind = TX_VALID && TX_ID[6:0] == NODE_NUMBER ? TX_ID[10:7] : 4'h0;
    sequence s_boot;
        kind == 4'he && TX_DLC == 4'h1 && TX_DATA[7:0] == 8'h00;
    endsequence
    sequence s_held;
        TX_VALID && $stable(TX_DATA) && $stable(TX_ID);
    endsequence
    a_stall_frame_hold: assert property (TX_VALID && !TX_READY |=> s_held)
        else $error("stalled frame changed");
    a_boot_frame_out: assert property ($rose(RST_N) |-> ##[1:3] s_boot)
        else $error("no boot frame");
    a_boot_state_preop: assert property ($rose(RST_N) |=> NMT_STATE == 8'h7f)
        else $error("no pre-operational after boot");
    a_sdo_reply_len: assert property (kind == 4'hb |-> TX_DLC == 4'h8)
        else $error("reply length");
    a_sdo_reply_code: assert property (kind == 4'hb |->
        TX_DATA[7:0] inside {8'h60, 8'h80, 8'h4f, 8'h4b, 8'h47, 8'h43}) else $error("reply code");
    a_pdo_frame_len: assert property (kind == 4'h3 |-> TX_DLC == 4'h8)
        else $error("pdo length");
    a_emcy_frame_fields: assert property (kind == 4'h1 |-> TX_DATA[63:56] == 8'h00
        && TX_DATA[16] == |TX_DATA[55:24]) else $error("emergency fields");
    a_ts_preop_only: assert property (TS_VALID |-> NMT_STATE == 8'h7f)
        else $error("time stamp outside pre-operational");
endmodule // csn_node_properties
bind csn_node csn_node_properties u_props (.*);
`default_nettype wire

// File: testbench/csn_master_model.sv
// Network master model for the node's frame ports
`timescale 1ns/10ps
`default_nettype none
module csn_master_model (
    input wire logic clk,
    input wire logic slow,
    output logic rx_valid,
    output logic [10:0] rx_id,
    output logic rx_rtr,
    output logic [3:0] rx_dlc,
    output logic [63:0] rx_data,
    output logic tx_ready
);
    initial begin
        {rx_valid, rx_id, rx_rtr, rx_dlc, rx_data, tx_ready} = '0;
    end
    // Random stalls load the node's queue
    always @(negedge clk) tx_ready <= slow ? 1'($urandom_range(1)) : 1'b1;
    task automatic send(input logic [10:0] id, input logic r, input logic [3:0] n,
        input logic [63:0] d);
        @(negedge clk);
        {rx_valid, rx_id, rx_rtr, rx_dlc, rx_data} = {1'b1, id, r, n, d};
        @(negedge clk);
        rx_valid = 1'b0;
        // Idle bus never repeats the last payload
        rx_data = ~d;
    endtask
endmodule // csn_master_model
`default_nettype wire

// File: testbench/csn_node_tb_top.sv
// Self-checking bench for the sensor node
`timescale 1ns/10ps
`default_nettype none
module csn_node_tb_top;
    logic clk, rst_n, slow, flt, rxv, rtr, txv, txr, tsv;
    logic [6:0] nd;
    logic [10:0] rid, tid;
    logic [3:0] rdl, tdl;
    logic [63:0] rd, td, pvi;
    logic [127:0] pvr;
    logic [39:0] now;
    logic [27:0] tms;
    logic [15:0] tdy;
    logic [7:0] st;
    logic [78:0] exp_q[$];
    int errors, check_count, i;
    csn_node #(.MEAS_CYCLES(32'd200), .MS_CYCLES(32'd10)) dut (.SYS_CLK(clk), .RST_N(rst_n),
        .NODE_NUMBER(nd), .RX_VALID(rxv), .RX_ID(rid), .RX_RTR(rtr), .RX_DLC(rdl),
        .RX_DATA(rd), .TX_VALID(txv), .TX_READY(txr), .TX_ID(tid), .TX_DLC(tdl), .TX_DATA(td),
        .PV_INT(pvi), .PV_REAL(pvr), .FLOW_FAULT(flt), .CLOCK_NOW(now), .TS_VALID(tsv),
        .TS_MS(tms), .TS_DAYS(tdy), .NMT_STATE(st));
    csn_master_model master (.clk(clk), .slow(slow), .rx_valid(rxv), .rx_id(rid),
        .rx_rtr(rtr), .rx_dlc(rdl), .rx_data(rd), .tx_ready(txr));
    task automatic chk(input logic [78:0] e, input logic [78:0] g, input string what);
        check_count++;
        if (e !== g) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic note(input logic [10:0] b, input logic [3:0] n, input logic [63:0] d);
        exp_q.push_back({b + 11'(nd), n, d});
    endtask
    // Unsolicited frames skipped; oldest note with same identifier taken
    always @(posedge clk) if (txv && txr) begin
        for (int k = 0; k < exp_q.size(); k++) if (exp_q[k][78:68] === tid) begin
            chk(exp_q[k], {tid, tdl, td}, "tx frame");
            exp_q.delete(k);
            break;
        end
    end
    task automatic drain(input int lim);
        for (int k = 0; k < lim && exp_q.size() > 0; k++) @(negedge clk);
        if (exp_q.size() > 0) begin
            chk(79'h0, 79'(exp_q.size()), "pending frames");
            end_of_test;
        end
    endtask
    task automatic sdo(input logic [7:0] c, input logic [15:0] x, input logic [7:0] s,
        input logic [31:0] d, input logic [7:0] rc, input logic [31:0] r);
        note(11'h580, 4'h8, {r, s, x, rc});
        master.send(11'h600 + 11'(nd), 1'b0, 4'h8, {d, s, x, c});
        drain(60);
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        errors = 0;
        check_count = 0;
        {rst_n, slow, flt} = 3'b010;
        void'($urandom(32'h8d83));
        nd = 7'($urandom_range(127, 1));
        pvi = {$urandom, $urandom};
        pvr = {$urandom, $urandom, $urandom, $urandom};
        now = {8'($urandom), $urandom};
        note(11'h700, 4'h1, 64'h0);
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        drain(40);
        sdo(8'h2b, 16'h4000, 8'h0, 32'd1001, 8'h80, 32'h06090030);
        sdo(8'h2b, 16'h4000, 8'h0, 32'd1000, 8'h60, 32'h0);
        sdo(8'h2b, 16'h5000, 8'h1, 32'h0, 8'h80, 32'h06010002);
        for (i = 0; i < 4; i++) begin
            sdo(8'h2f - 8'(i * 4), 16'h3003, 8'h0, 32'h1, 8'h60, 32'h0);
            sdo(8'h40, 16'h5000, 8'(i + 1), 32'h0, 8'h4b, 32'(pvi[i*16+:16]));
            sdo(8'h40, 16'h5100, 8'(i + 1), 32'h0, 8'h43, pvr[i*32+:32]);
        end
        $display("sdo test done");
        sdo(8'h2b, 16'h4000, 8'h0, 32'h1, 8'h60, 32'h0);
        // One stored record needs 180 measurements of 200 cycles
        repeat (36400) @(negedge clk);
        sdo(8'h2b, 16'h4000, 8'h0, 32'h0, 8'h60, 32'h0);
        sdo(8'h40, 16'h4001, 8'h0, 32'h0, 8'h4b, 32'h1);
        sdo(8'h40, 16'h4002, 8'h6, 32'h0, 8'h43, pvr[31:0]);
        sdo(8'h2b, 16'h4001, 8'h0, 32'h0, 8'h60, 32'h0);
        sdo(8'h40, 16'h4002, 8'h1, 32'h0, 8'h80, 32'h06010000);
        sdo(8'h23, 16'h1012, 8'h0, 32'h80000100, 8'h60, 32'h0);
        master.send(11'h100, 1'b0, 4'h6, {16'h0, pvi[15:0], 4'h0, pvi[59:32]});
        for (i = 0; i < 5 && tsv !== 1'b1; i++) @(posedge clk);
        chk({34'h1, pvi[15:0], pvi[59:32]}, {34'(tsv), tdy, tms}, "time stamp");
        if (tsv !== 1'b1) end_of_test;
        $display("log test done");
        for (i = 0; i < 2; i++) begin
            note(11'h700, 4'h1, {56'h0, 1'(i), 7'h7f});
            master.send(11'h700 + 11'(nd), 1'b1, 4'h1, 64'h0);
            drain(60);
        end
        sdo(8'h2b, 16'h1017, 8'h0, 32'h5, 8'h60, 32'h0);
        note(11'h700, 4'h1, 64'h7f);
        drain(200);
        sdo(8'h2b, 16'h1017, 8'h0, 32'h0, 8'h60, 32'h0);
        master.send(11'h0, 1'b0, 4'h2, 64'h1);
        note(11'h180, 4'h8, pvi);
        drain(600);
        note(11'h180, 4'h8, pvi);
        master.send(11'h180 + 11'(nd), 1'b1, 4'h0, 64'h0);
        drain(60);
        flt = 1'b1;
        note(11'h080, 4'h8, 64'h0000000101ff00);
        drain(60);
        flt = 1'b0;
        note(11'h080, 4'h8, 64'h0);
        drain(60);
        master.send(11'h0, 1'b0, 4'h2, {48'h0, 1'b0, nd, 8'h02});
        @(negedge clk);
        chk(79'(8'h04), 79'(st), "node state");
        note(11'h700, 4'h1, 64'h0);
        master.send(11'h0, 1'b0, 4'h2, 64'h82);
        drain(60);
        $display("nmt test done");
        end_of_test;
    end
endmodule // csn_node_tb_top
`default_nettype wire
